// [smbus_slave_pkg.sv]
// Constants, register offsets and state codes for the bus slave.
// Assumes a 40 MHz system clock; shared by the slave, its checker and the bench.
package smbus_slave_pkg;
    // --------------------------------------------------------------
    // Addressing and register offsets
    // --------------------------------------------------------------
    localparam logic [4:0] ADDR_UPPER = 5'h15;
    localparam logic [7:0] RAM_LAST = 8'hDF;
    localparam logic [7:0] REG_UPDATE = 8'h90;
    localparam logic [7:0] REG_MAKER = 8'h93;
    localparam logic [7:0] REG_PART = 8'h94;
    localparam logic [7:0] REG_REV = 8'h95;
    localparam logic [7:0] REG_BRAND1 = 8'h96;
    localparam logic [7:0] REG_BRAND2 = 8'h97;
    localparam logic [7:0] EE_HIGH_FIRST = 8'hF8;
    localparam logic [7:0] EE_HIGH_LAST = 8'hF9;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'hFC;
    localparam logic [7:0] CMD_BLOCK_READ = 8'hFD;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'hFE;
    localparam logic [7:0] BLOCK_COUNT = 8'h20;
    localparam logic [7:0] BLANK_BYTE = 8'h00;
    localparam int EE_PAGES = 16;
    localparam int EE_PAGE_BYTES = 32;
    localparam int EE_BYTES = EE_PAGES * EE_PAGE_BYTES;
    localparam int RAM_BYTES = 224;
    // --------------------------------------------------------------
    // Update control fields
    // --------------------------------------------------------------
    localparam int UPD_REALTIME_BIT = 0;
    localparam int UPD_RAMLD_BIT = 1;
    localparam int UPD_EELOAD_BIT = 2;
    localparam int UPD_ERASE_EN_BIT = 3;
    localparam logic [7:0] UPD_RESET = 8'h00;
    // --------------------------------------------------------------
    // Bit positions within a nine-clock byte
    // --------------------------------------------------------------
    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;
    localparam logic [5:0] IDX_MAX = 6'h3F;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int ERASE_TIME_US = 20000;
    localparam int PROG_TIME_US = 250;
    localparam int ERASE_CYCLES = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    // --------------------------------------------------------------
    // Link states, Gray coded along idle-addr-write-read
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_write = 3'b011,
        st_read = 3'b010,
        st_skip = 3'b110
    } link_state_t;
endpackage

// [smbus_slave.sv]
// Bus slave giving an external master access to config RAM and paged EEPROM.
// Assumes open-drain SCL/SDA resolved outside; SCL also clocks the input shifter.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Answer address 10101 plus the two address-select pin levels.
// R2: Identification bytes readable at 0x93 to 0x97, writes ignored.
// R3: Address byte arrives MSB first, last bit 0 write, 1 read.
// R4: Addressed slave pulls SDA low for ninth clock; others stay idle.
// R5: Master moves SDA only while SCL low except START and STOP.
// R6: First write byte after address is a command or register address.
// R7: Master ends a read with no acknowledge then STOP.
// R8: RAM 0x00-0xDF and EEPROM 0xF800-0xF9FF byte readable and writable.
// R9: EEPROM programs only blank bytes; erase whole 32-byte pages, 16 pages.
// R10: Page erase happens only when update_control bit 3 is set.
// R11: Send byte with RAM address loads the pointer for later accesses.
// R12: Command 0xFE erases the page of the previously set EEPROM address.
// R13: Erase starts at once, lasts 20 ms; accesses meanwhile get no acknowledge.
// R14: Write byte with RAM command stores the data byte there.
// R15: Command 0xF8/0xF9 plus one data byte sets the EEPROM pointer.
// R16: Erase uses only the top three bits of the low address byte.
// R17: Write word to EEPROM: first byte low address, second programmed.
// R18: Block write: 0xFC, count, data bytes; every byte acknowledged, up to 32.
// R19: Master keeps block writes within 0xF9FF and pre-erases spanned pages.
// R20: SCL held low while an EEPROM byte programs, 250 us each.
// R21: Block read 0xFD returns count 0x20 then 32 bytes from the pointer.
// R22: No acknowledge until power-up configuration transfer is done.
// R23: Pointer advances by one after each block byte.
module smbus_slave
    import smbus_slave_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT = PROG_CYCLES,
    parameter logic [7:0] MAKER_VALUE = 8'hA5, // Arbitrary value
    parameter logic [7:0] PART_VALUE = 8'h5C, // Arbitrary value
    parameter logic [7:0] REV_VALUE = 8'h01, // Arbitrary value
    parameter logic [7:0] BRAND1_VALUE = 8'h00, // Arbitrary value
    parameter logic [7:0] BRAND2_VALUE = 8'h00 // Arbitrary value
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic scl_link, // SCL pin level, also the link clock
    output logic scl_o, // SCL drive value, always low
    output logic scl_oe, // High while stretching SCL low
    input wire logic sda_i, // SDA pin level
    output logic sda_o, // SDA drive value, always low
    output logic sda_oe, // High while pulling SDA low
    input wire logic addr_select_high_pin, // Address bit 1 strap
    input wire logic addr_select_low_pin, // Address bit 0 strap
    input wire logic boot_done, // Power-up configuration transfer finished
    output logic realtime_update, // update_control bit 0
    output logic latch_update_pulse, // One-cycle pulse from bit 1 write
    output logic eeprom_reload_pulse, // One-cycle pulse from bit 2 write
    output logic erase_busy, // Page erase in progress
    output logic program_busy // EEPROM byte programming in progress
);
    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    logic [7:0] ram [RAM_BYTES];
    logic [7:0] eeprom [EE_BYTES];
    logic [7:0] update_control;

    // --------------------------------------------------------------
    // Link clock domain: input shifter
    // --------------------------------------------------------------
    logic [7:0] link_shift;

    always_ff @(posedge scl_link or negedge arst_n) begin
        if (!arst_n) begin
            link_shift <= 8'h00;
        end else begin
            link_shift <= {link_shift[6:0], sda_i}; // R3
        end
    end

    // --------------------------------------------------------------
    // Synchronisers; shifter word is stable from the eighth SCL rise until the ninth
    // --------------------------------------------------------------
    logic scl_meta, scl_s, scl_prev;
    logic sda_meta, sda_s, sda_prev;
    logic [1:0] sel_meta, sel_s;
    logic [7:0] rx_meta, rx_byte;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {scl_prev, scl_s, scl_meta} <= 3'h7;
            {sda_prev, sda_s, sda_meta} <= 3'h7;
            {sel_s, sel_meta} <= 4'h0;
            {rx_byte, rx_meta} <= 16'h0000;
        end else begin
            {scl_prev, scl_s, scl_meta} <= {scl_s, scl_meta, scl_link};
            {sda_prev, sda_s, sda_meta} <= {sda_s, sda_meta, sda_i};
            {sel_s, sel_meta} <= {sel_meta, addr_select_high_pin, addr_select_low_pin};
            {rx_byte, rx_meta} <= {rx_meta, link_shift};
        end
    end

    logic start_ev, stop_ev, rise_ev, fall_ev, byte_done, ack_done;
    logic [3:0] bit_cnt;

    assign start_ev = scl_s && scl_prev && sda_prev && !sda_s;
    assign stop_ev = scl_s && scl_prev && !sda_prev && sda_s;
    assign rise_ev = scl_s && !scl_prev;
    assign fall_ev = !scl_s && scl_prev;
    assign byte_done = fall_ev && (bit_cnt == BIT_LAST_DATA);
    assign ack_done = fall_ev && (bit_cnt == BIT_ACK);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt <= 4'h0;
        end else if (start_ev || stop_ev || ack_done) begin
            bit_cnt <= 4'h0;
        end else if (rise_ev && bit_cnt != BIT_ACK) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    // --------------------------------------------------------------
    // Address decoding helpers
    // --------------------------------------------------------------
    function automatic logic is_ram(input logic [15:0] a);
        return (a[15:8] == 8'h00) && (a[7:0] <= RAM_LAST);
    endfunction

    function automatic logic is_ee(input logic [15:0] a);
        return (a[15:8] == EE_HIGH_FIRST) || (a[15:8] == EE_HIGH_LAST);
    endfunction

    function automatic logic [7:0] read_at(input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (is_ram(a)) begin
            unique case (a[7:0])
                REG_UPDATE: v = update_control;
                REG_MAKER: v = MAKER_VALUE; // R2
                REG_PART: v = PART_VALUE;
                REG_REV: v = REV_VALUE;
                REG_BRAND1: v = BRAND1_VALUE;
                REG_BRAND2: v = BRAND2_VALUE;
                default: v = ram[a[7:0]]; // R8
            endcase
        end else if (is_ee(a)) begin
            v = eeprom[a[8:0]]; // R8
        end
        return v;
    endfunction

    // --------------------------------------------------------------
    // Transaction decode
    // --------------------------------------------------------------
    link_state_t state;
    logic dir_read, master_ack, blk_rd, cnt_sent;
    logic [5:0] byte_idx;
    logic [7:0] cmd, blk_cnt, blk_done;
    logic [15:0] ptr;
    logic [7:0] tx_sh, tx_next;
    logic addr_match, dev_avail, load_tx;
    logic store, erase_go;
    logic [15:0] store_addr;

    assign addr_match = rx_byte[7:1] == {ADDR_UPPER, sel_s}; // R1
    assign dev_avail = boot_done && !erase_busy; // R13 R22
    assign load_tx = ack_done && ((state == st_addr && dir_read) || (state == st_read && master_ack));
    assign tx_next = (blk_rd && !cnt_sent) ? BLOCK_COUNT : read_at(ptr); // R21

    always_comb begin
        store = 1'b0;
        store_addr = ptr;
        erase_go = 1'b0;
        if (state == st_write && byte_done) begin
            if (byte_idx == 6'h00) begin
                erase_go = (rx_byte == CMD_PAGE_ERASE) && update_control[UPD_ERASE_EN_BIT]
                    && is_ee(ptr); // R10 R12 R13
            end else if (byte_idx == 6'h01 && is_ram({8'h00, cmd})) begin
                store = 1'b1; // R14
                store_addr = {8'h00, cmd};
            end else if (byte_idx == 6'h02 && (cmd == EE_HIGH_FIRST || cmd == EE_HIGH_LAST)) begin
                store = 1'b1; // R17
            end else if (cmd == CMD_BLOCK_WRITE && byte_idx >= 6'h02) begin
                store = (blk_done < blk_cnt) && (blk_done < BLOCK_COUNT); // R18
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_idle;
            dir_read <= 1'b0;
            master_ack <= 1'b0;
            blk_rd <= 1'b0;
            cnt_sent <= 1'b0;
            byte_idx <= 6'h00;
            cmd <= 8'h00;
            blk_cnt <= 8'h00;
            blk_done <= 8'h00;
            ptr <= PTR_RESET;
            tx_sh <= 8'h00;
        end else if (start_ev) begin
            state <= st_addr;
            byte_idx <= 6'h00;
        end else if (stop_ev) begin
            state <= st_idle;
        end else begin
            if (rise_ev && bit_cnt == BIT_LAST_DATA) begin
                master_ack <= !sda_s;
            end
            if (load_tx) begin
                tx_sh <= tx_next;
                if (blk_rd && !cnt_sent) begin
                    cnt_sent <= 1'b1;
                end else if (blk_rd) begin
                    ptr <= ptr + 16'h0001; // R23
                end
            end
            unique case (state)
                st_idle, st_skip: begin
                end
                st_addr: begin
                    if (byte_done) begin
                        if (addr_match && dev_avail) begin
                            dir_read <= rx_byte[0]; // R3
                        end else begin
                            state <= st_skip; // R4
                        end
                    end else if (ack_done) begin
                        state <= dir_read ? st_read : st_write;
                    end
                end
                st_read: begin
                    if (ack_done && !master_ack) begin
                        state <= st_skip; // R7
                        blk_rd <= 1'b0;
                    end
                end
                st_write: begin
                    if (byte_done) begin
                        if (byte_idx != IDX_MAX) begin
                            byte_idx <= byte_idx + 6'h01;
                        end
                        if (byte_idx == 6'h00) begin
                            cmd <= rx_byte; // R6
                            blk_rd <= rx_byte == CMD_BLOCK_READ; // R21
                            blk_done <= 8'h00;
                            cnt_sent <= 1'b0;
                            if (rx_byte <= RAM_LAST) begin
                                ptr <= {8'h00, rx_byte}; // R11
                            end
                        end else if (byte_idx == 6'h01 && (cmd == EE_HIGH_FIRST || cmd == EE_HIGH_LAST)) begin
                            ptr <= {cmd, rx_byte}; // R15
                        end else if (byte_idx == 6'h01 && cmd == CMD_BLOCK_WRITE) begin
                            blk_cnt <= rx_byte; // R18
                        end else if (store && cmd == CMD_BLOCK_WRITE) begin
                            blk_done <= blk_done + 8'h01;
                            ptr <= ptr + 16'h0001; // R23
                        end
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // SDA drive: acknowledge and read data
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sda_oe <= 1'b0;
        end else if (start_ev || stop_ev) begin
            sda_oe <= 1'b0;
        end else if (byte_done) begin
            sda_oe <= (state == st_addr && addr_match && dev_avail) || state == st_write; // R4 R18
        end else if (ack_done) begin
            sda_oe <= load_tx && !tx_next[7];
        end else if (fall_ev && state == st_read && bit_cnt != 4'h0) begin
            sda_oe <= !tx_sh[3'(7 - bit_cnt)];
        end
    end

    assign sda_o = 1'b0;
    assign scl_o = 1'b0;

    // --------------------------------------------------------------
    // RAM, EEPROM array and update control
    // --------------------------------------------------------------
    logic prog_go;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            update_control <= UPD_RESET;
            latch_update_pulse <= 1'b0;
            eeprom_reload_pulse <= 1'b0;
            prog_go <= 1'b0;
        end else begin
            latch_update_pulse <= 1'b0;
            eeprom_reload_pulse <= 1'b0;
            prog_go <= 1'b0;
            if (store && is_ram(store_addr)) begin
                if (store_addr[7:0] == REG_UPDATE) begin
                    update_control[UPD_REALTIME_BIT] <= rx_byte[UPD_REALTIME_BIT];
                    update_control[UPD_ERASE_EN_BIT] <= rx_byte[UPD_ERASE_EN_BIT];
                    latch_update_pulse <= rx_byte[UPD_RAMLD_BIT];
                    eeprom_reload_pulse <= rx_byte[UPD_EELOAD_BIT];
                end else if (store_addr[7:0] < REG_MAKER || store_addr[7:0] > REG_BRAND2) begin
                    ram[store_addr[7:0]] <= rx_byte; // R2 R8
                end
            end else if (store && is_ee(store_addr) && eeprom[store_addr[8:0]] == BLANK_BYTE) begin
                eeprom[store_addr[8:0]] <= rx_byte; // R9
                prog_go <= 1'b1; // R20
            end
            if (erase_go) begin
                for (int i = 0; i < EE_PAGE_BYTES; i++) begin
                    eeprom[{ptr[8:5], 5'(i)}] <= BLANK_BYTE; // R9 R16
                end
            end
        end
    end

    assign realtime_update = update_control[UPD_REALTIME_BIT];

    logic [19:0] erase_cnt;
    logic [19:0] prog_cnt;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            erase_cnt <= 20'h0_0000;
        end else if (erase_go) begin
            erase_cnt <= 20'(ERASE_CNT); // R13
        end else if (erase_cnt != 20'h0_0000) begin
            erase_cnt <= erase_cnt - 20'h0_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prog_cnt <= 20'h0_0000;
        end else if (prog_go) begin
            prog_cnt <= 20'(PROG_CNT); // R20
        end else if (prog_cnt != 20'h0_0000) begin
            prog_cnt <= prog_cnt - 20'h0_0001;
        end
    end

    assign erase_busy = erase_cnt != 20'h0_0000;
    assign program_busy = prog_cnt != 20'h0_0000;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_oe <= 1'b0;
        end else if (!program_busy) begin
            scl_oe <= 1'b0;
        end else if (!scl_s) begin
            scl_oe <= 1'b1; // R20
        end
    end
endmodule

// [smbus_slave_sva.sv]
// Checker for the bus slave, watching the top ports only.
// Assumes one clk_sys domain; SCL and SDA are sampled as data.
`timescale 1ns/1ps
module smbus_slave_sva
    import smbus_slave_pkg::*;
#(
    parameter int ERASE_CNT = 50,
    parameter int PROG_CNT = 20
) (
    input wire logic clk_sys, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic scl_link, // SCL level
    input wire logic scl_o, // SCL drive value
    input wire logic scl_oe, // SCL stretch enable
    input wire logic sda_i, // SDA level
    input wire logic sda_o, // SDA drive value
    input wire logic sda_oe, // SDA pull enable
    input wire logic addr_select_high_pin, // Address strap bit 1
    input wire logic addr_select_low_pin, // Address strap bit 0
    input wire logic boot_done, // Boot transfer finished
    input wire logic realtime_update, // Update bit 0
    input wire logic latch_update_pulse, // Latch pulse
    input wire logic eeprom_reload_pulse, // Reload pulse
    input wire logic erase_busy, // Erase running
    input wire logic program_busy // Programming running
);
    int ecnt;
    int pcnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Cycles spent busy so far
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ecnt <= 0;
            pcnt <= 0;
        end else begin
            ecnt <= erase_busy ? ecnt + 1 : 0;
            pcnt <= program_busy ? pcnt + 1 : 0;
        end
    end
    sequence s_stretch_gone;
        ##[0:2] !scl_oe;
    endsequence
    a_nack_before_boot: assert property (!boot_done |-> !sda_oe)
        else $error("SDA pulled before boot finished");
    a_erase_length: assert property ($fell(erase_busy) |-> ecnt == ERASE_CNT)
        else $error("erase time wrong");
    a_erase_nack: assert property (erase_busy && ecnt > 60 |-> !sda_oe)
        else $error("SDA pulled during erase");
    a_prog_length: assert property ($fell(program_busy) |-> pcnt == PROG_CNT)
        else $error("program time wrong");
    a_stretch_cause: assert property ($rose(scl_oe) |-> $past(program_busy))
        else $error("SCL stretched without programming");
    a_stretch_release: assert property ($fell(program_busy) |-> s_stretch_gone)
        else $error("SCL held after programming");
    a_ack_low_phase: assert property ($rose(sda_oe) |-> !scl_link)
        else $error("SDA pulled while SCL high");
    a_release_low_phase: assert property ($fell(sda_oe) |-> !scl_link)
        else $error("SDA released while SCL high");
    a_drive_zero: assert property (sda_oe || scl_oe |-> !sda_o && !scl_o)
        else $error("open-drain drive value not low");
    a_update_store: assert property ($changed(realtime_update) || latch_update_pulse || eeprom_reload_pulse |-> $rose(sda_oe))
        else $error("update control acted outside a stored byte");
endmodule
bind smbus_slave smbus_slave_sva #(.ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_link(scl_link), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_high_pin(addr_select_high_pin),
    .addr_select_low_pin(addr_select_low_pin), .boot_done(boot_done), .realtime_update(realtime_update),
    .latch_update_pulse(latch_update_pulse), .eeprom_reload_pulse(eeprom_reload_pulse),
    .erase_busy(erase_busy), .program_busy(program_busy));

// [smbus_master_model.sv]
// Behavioural bus master with pull-ups on SCL and SDA.
// Assumes a free bit tick; SCL stands high outside frames.
`timescale 1ns/1ps
module smbus_master_model (
    input wire logic lclk, // Bit timing tick
    input wire logic scl_oe, // Slave holds SCL low
    input wire logic sda_oe, // Slave pulls SDA low
    output logic scl_link, // Resolved SCL
    output logic sda_i // Resolved SDA
);
    logic m_scl_low = 1'b0;
    logic m_sda_low = 1'b0;
    logic [7:0] got_val;
    event got;
    assign scl_link = ~(m_scl_low | scl_oe);
    assign sda_i = ~(m_sda_low | sda_oe);
    task automatic tk(input int n);
        repeat (n) @(posedge lclk);
    endtask
    task automatic rise_scl();
        m_scl_low = 1'b0;
        for (int g = 0; g < 4000 && !scl_link; g++) tk(1);
        tk(4);
    endtask
    // SDA moves only while SCL is low
    task automatic bit_io(input logic b, output logic seen);
        tk(4);
        m_sda_low = ~b;
        tk(4);
        rise_scl();
        seen = sda_i;
        tk(4);
        m_scl_low = 1'b1;
    endtask
    task automatic start_cond();
        tk(4);
        m_sda_low = 1'b0;
        tk(4);
        rise_scl();
        m_sda_low = 1'b1;
        tk(4);
        m_scl_low = 1'b1;
    endtask
    task automatic stop_cond();
        tk(4);
        m_sda_low = 1'b1;
        tk(4);
        rise_scl();
        m_sda_low = 1'b0;
        tk(8);
    endtask
    task automatic wr(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        got_val = {7'h00, ~s};
        ->got;
    endtask
    task automatic rd(input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            got_val[i] = s;
        end
        bit_io(~ack, s);
        ->got;
    endtask
endmodule

// [smbus_slave_ram_eeprom_access_bench.sv]
// Self-checking bench: master model against the slave, checker bound in.
// Assumes shortened erase and program counts.
`timescale 1ns/1ps
module smbus_slave_ram_eeprom_access_bench;
    import smbus_slave_pkg::*;
    localparam logic [7:0] ID_V [5] = '{8'h6B, 8'h2D, 8'h03, 8'h11, 8'h7E}; // Arbitrary identity values
    logic clk_sys = 1'b0;
    logic lclk = 1'b0;
    logic arst_n = 1'b0;
    logic boot_done = 1'b0;
    logic pin_hi = 1'b0;
    logic pin_lo = 1'b0;
    logic scl_link, sda_i, scl_oe, sda_oe, erase_busy, program_busy;
    logic [7:0] aw, d;
    logic [7:0] blk [3];
    logic [2:0] pg;
    logic [4:0] off;
    logic [8:0] e_note;
    logic [8:0] exp_q [$];
    int n_mismatch = 0;
    int total_checks = 0;
    smbus_slave #(.ERASE_CNT(2000), .PROG_CNT(100), .MAKER_VALUE(ID_V[0]), .PART_VALUE(ID_V[1]),
        .REV_VALUE(ID_V[2]), .BRAND1_VALUE(ID_V[3]), .BRAND2_VALUE(ID_V[4])) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .scl_link(scl_link), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_i),
        .sda_o(), .sda_oe(sda_oe), .addr_select_high_pin(pin_hi), .addr_select_low_pin(pin_lo),
        .boot_done(boot_done), .realtime_update(), .latch_update_pulse(), .eeprom_reload_pulse(),
        .erase_busy(erase_busy), .program_busy(program_busy));
    smbus_master_model u_m (.lclk(lclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_link(scl_link), .sda_i(sda_i));
    initial forever #12.5 clk_sys = ~clk_sys;
    initial forever #16 lclk = ~lclk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp_ack(input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED ack expected %b seen %b", e, s);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED read byte expected %h seen %h", e, s);
        end
    endtask
    task automatic note(input logic is_ack, input logic [7:0] v);
        exp_q.push_back({is_ack, v});
    endtask
    task automatic xfer(input logic [7:0] bytes[$], input logic ok);
        u_m.start_cond();
        foreach (bytes[i]) begin
            note(1'b1, {7'h00, ok});
            u_m.wr(bytes[i]);
        end
        u_m.stop_cond();
    endtask
    task automatic rd_at(input logic [7:0] e);
        u_m.start_cond();
        note(1'b1, 8'h01);
        u_m.wr(aw | 8'h01);
        note(1'b0, e);
        u_m.rd(1'b0);
        u_m.stop_cond();
    endtask
    task automatic blk_read(input logic [7:0] e[$]);
        u_m.start_cond();
        note(1'b1, 8'h01);
        u_m.wr(aw);
        note(1'b1, 8'h01);
        u_m.wr(CMD_BLOCK_READ);
        u_m.start_cond();
        note(1'b1, 8'h01);
        u_m.wr(aw | 8'h01);
        foreach (e[i]) begin
            note(1'b0, e[i]);
            u_m.rd(i < e.size() - 1);
        end
        u_m.stop_cond();
    endtask
    task automatic wait_erase();
        for (int k = 0; k < 4000 && erase_busy !== 1'b0; k++) @(negedge clk_sys);
    endtask
    // Watcher pairs each result with the oldest note
    initial forever begin
        @(u_m.got);
        e_note = exp_q.pop_front();
        if (e_note[8]) cmp_ack(e_note[0], u_m.got_val[0]);
        else cmp_byte(e_note[7:0], u_m.got_val);
    end
    initial begin
        #2ms;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(57));
        {pin_hi, pin_lo, pg, off, d} = 18'($urandom()) | 18'h0_0001;
        foreach (blk[i]) blk[i] = 8'($urandom());
        aw = {ADDR_UPPER, pin_hi, pin_lo, 1'b0};
        repeat (12) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        xfer('{aw, 8'h10}, 1'b0);
        boot_done = 1'b1;
        foreach (ID_V[i]) xfer('{aw ^ (8'h02 << i), 8'h10}, 1'b0);
        xfer('{aw, 8'h10, d}, 1'b1);
        xfer('{aw, 8'h10}, 1'b1);
        rd_at(d);
        for (int i = 0; i < 5; i++) begin
            xfer('{aw, REG_MAKER + 8'(i), 8'hFF}, 1'b1);
            xfer('{aw, REG_MAKER + 8'(i)}, 1'b1);
            rd_at(ID_V[i]);
        end
        xfer('{aw, REG_UPDATE, 8'h09}, 1'b1);
        xfer('{aw, 8'hF9, {pg, off}}, 1'b1);
        xfer('{aw, CMD_PAGE_ERASE}, 1'b1);
        xfer('{aw, 8'hF9, {pg, off}}, 1'b0);
        wait_erase();
        xfer('{aw, 8'hF9, {pg, off}, d}, 1'b1);
        xfer('{aw, 8'hF9, {pg, off}, ~d}, 1'b1);
        xfer('{aw, REG_UPDATE, 8'h01}, 1'b1);
        xfer('{aw, 8'hF9, {pg, off}}, 1'b1);
        xfer('{aw, CMD_PAGE_ERASE}, 1'b1);
        rd_at(d);
        xfer('{aw, REG_UPDATE, 8'h0F}, 1'b1);
        xfer('{aw, 8'hF9, {pg, ~off}}, 1'b1);
        xfer('{aw, CMD_PAGE_ERASE}, 1'b1);
        wait_erase();
        xfer('{aw, 8'hF9, {pg, off}}, 1'b1);
        rd_at(BLANK_BYTE);
        xfer('{aw, 8'hF9, {pg, 5'h00}}, 1'b1);
        xfer('{aw, CMD_BLOCK_WRITE, 8'h03, blk[0], blk[1], blk[2]}, 1'b1);
        xfer('{aw, 8'hF9, {pg, 5'h00}}, 1'b1);
        blk_read('{BLOCK_COUNT, blk[0], blk[1], blk[2]});
        end_of_test();
    end
endmodule
